/* phm_pkg.sv */
package phm_pkg;
	// ----------------------------------------------------------------
	// register select codes
	// ----------------------------------------------------------------
	localparam logic [1:0] ADDR_MESSAGE    = 2'h0;
	localparam logic [1:0] ADDR_CONTROL    = 2'h1;
	localparam logic [1:0] ADDR_PCM        = 2'h2;
	localparam logic [1:0] ADDR_COMPRESSED = 2'h3;
	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int BIT_OUT_READY = 1;
	localparam int BIT_IN_BUSY   = 2;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	// ----------------------------------------------------------------
	// message lengths and timing
	// ----------------------------------------------------------------
	localparam logic [2:0] BOOT_WRITE_LEN = 3'h3;
	localparam logic [2:0] BOOT_READ_LEN  = 3'h1;
	localparam logic [2:0] RUN_READ_LEN   = 3'h6;
	localparam int CLK_MHZ            = 100;
	localparam int UNSOLICITED_WAIT_US = 100;
	localparam int UNSOLICITED_WAIT_CYC = UNSOLICITED_WAIT_US * CLK_MHZ;
	// the device needs three synchroniser stages and one register stage
	// before its read data stands, so the strobe must outlast that
	localparam int STROBE_LOW_CYC = 5;
	// ----------------------------------------------------------------
	// wishbone register offsets of the host controller
	// ----------------------------------------------------------------
	localparam logic [3:0] WB_TX_DATA = 4'h0;
	localparam logic [3:0] WB_RX_DATA = 4'h4;
	localparam logic [3:0] WB_STATUS  = 4'h8;
	localparam logic [3:0] WB_CONFIG  = 4'hC;
	localparam int ST_TX_BUSY  = 0;
	localparam int ST_RX_VALID = 1;
	localparam int ST_UNSOL    = 2;
	localparam int ST_IRQ      = 3;
	localparam int CFG_STROBE_MODE = 0;
	typedef enum logic [2:0] {
		H_IDLE    = 3'h0,
		H_POLL    = 3'h1,
		H_CHECK   = 3'h2,
		H_XFER    = 3'h3,
		H_GAP     = 3'h4
	} phm_host_state_t;
endpackage

/* phm_if.sv */
`timescale 1ns/1ps
interface phm_if;
	logic       chipSel_n;
	logic       writeStrobe_n;
	logic       readStrobe_n;
	logic       data_strobe_n;
	logic       readNotWrite;
	logic [1:0] regAddr;
	logic [7:0] hostData;
	logic       hostDataOe;
	logic [7:0] devData;
	logic       devDataOe;
	logic       message_pending_irq_n;
	logic       strobeMode;
	wire  [7:0] dataBus = hostDataOe ? hostData :
		(devDataOe ? devData : 8'hFF);
	modport device (
		input  chipSel_n, writeStrobe_n, readStrobe_n, data_strobe_n,
		input  readNotWrite, regAddr, hostData, hostDataOe, strobeMode,
		output devData, devDataOe, message_pending_irq_n
	);
	modport host (
		output chipSel_n, writeStrobe_n, readStrobe_n, data_strobe_n,
		output readNotWrite, regAddr, hostData, hostDataOe, strobeMode,
		input  devData, devDataOe, message_pending_irq_n
	);
endinterface

/* phm_device.sv */
`timescale 1ns/1ps
//
// Function
// - host sends messages most significant byte first
// - host never overwrites an unconsumed message byte
// - bit 2 busy; host polls until low
// - one byte to message register per poll
// - no fetch during service routine; busy stays
// - boot: three bytes in, one byte out
// - run time responses are six bytes
// - irq announces message; host still checks ready
// - no irq during boot
// - host reads control register before each read
// - bit 1 ready when outgoing byte valid
// - one message read per ready poll
// - host derives response length from opcode
// - after response wait 100 us, recheck ready
// - external memory unavailable in parallel mode
// - decode 00 message 01 control 10 pcm 11 compressed
// - separate strobe cycle with chip select
// - data strobe cycle with read/write select
module phm_device (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       clkEn,
	phm_if.device           bus,
	input  wire logic       inServiceRoutine,
	input  wire logic       bootDone,
	output logic      [7:0] rxByte,
	output logic            rxValid,
	input  wire logic       rxTake,
	input  wire logic [7:0] txByte,
	input  wire logic       txLoad,
	output logic            txSpace,
	output logic            extMemEnable,
	output logic      [7:0] pcmByte,
	output logic            pcmValid,
	output logic      [7:0] cmpByte,
	output logic            cmpValid
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] csSync;
		logic [2:0] wrSync;
		logic [2:0] rdSync;
		logic       accessOn;
		logic       accessRead;
		logic [1:0] accessAddr;
		logic [7:0] inMsg;
		logic       inBusy;
		logic [7:0] outMsg;
		logic       outReady;
		logic [7:0] devData;
		logic       devDataOe;
		logic       irq_n;
		logic [7:0] rxByte;
		logic       rxValid;
		logic [7:0] pcmByte;
		logic       pcmValid;
		logic [7:0] cmpByte;
		logic       cmpValid;
	} phm_dev_state_t;
	phm_dev_state_t st_reg;
	phm_dev_state_t st_next;
	logic csNow;
	logic wrNow;
	logic rdNow;
	logic [7:0] ctrlByte;
	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.csSync = {st_reg.csSync[1:0], ~bus.chipSel_n};
		st_next.wrSync = {st_reg.wrSync[1:0], bus.strobeMode ?
			(~bus.data_strobe_n & ~bus.readNotWrite) : ~bus.writeStrobe_n};
		st_next.rdSync = {st_reg.rdSync[1:0], bus.strobeMode ?
			(~bus.data_strobe_n & bus.readNotWrite) : ~bus.readStrobe_n};
		// a strobe counts only while stages two and three both show it
		csNow = st_reg.csSync[1] & st_reg.csSync[2];
		wrNow = csNow & st_reg.wrSync[1] & st_reg.wrSync[2];
		rdNow = csNow & st_reg.rdSync[1] & st_reg.rdSync[2];
		ctrlByte = phm_pkg::CONTROL_RESET;
		ctrlByte[phm_pkg::BIT_IN_BUSY] = st_reg.inBusy;
		ctrlByte[phm_pkg::BIT_OUT_READY] = st_reg.outReady;
		st_next.pcmValid = 1'b0;
		st_next.cmpValid = 1'b0;
		if ((wrNow || rdNow) && !st_reg.accessOn) begin
			st_next.accessOn = 1'b1;
			st_next.accessRead = rdNow;
			st_next.accessAddr = bus.regAddr;
			if (rdNow) begin
				unique case (bus.regAddr)
					phm_pkg::ADDR_MESSAGE: st_next.devData = st_reg.outMsg;
					phm_pkg::ADDR_CONTROL: st_next.devData = ctrlByte;
					phm_pkg::ADDR_PCM,
					phm_pkg::ADDR_COMPRESSED: st_next.devData = 8'h00;
				endcase
				st_next.devDataOe = (bus.regAddr == phm_pkg::ADDR_MESSAGE) ||
					(bus.regAddr == phm_pkg::ADDR_CONTROL);
			end
		end
		if (st_reg.accessOn && !wrNow && !rdNow) begin
			// data is latched at the end of the strobe, as the host
			// holds it valid right up to the rising edge
			st_next.accessOn = 1'b0;
			st_next.devDataOe = 1'b0;
			if (!st_reg.accessRead) begin
				unique case (st_reg.accessAddr)
					phm_pkg::ADDR_MESSAGE: begin
						// ignored while busy: the host broke the handshake
						if (!st_reg.inBusy) begin
							st_next.inMsg = bus.hostData;
							st_next.inBusy = 1'b1;
						end
					end
					phm_pkg::ADDR_CONTROL: ;
					phm_pkg::ADDR_PCM: begin
						st_next.pcmByte = bus.hostData;
						st_next.pcmValid = 1'b1;
					end
					phm_pkg::ADDR_COMPRESSED: begin
						st_next.cmpByte = bus.hostData;
						st_next.cmpValid = 1'b1;
					end
				endcase
			end else if (st_reg.accessAddr == phm_pkg::ADDR_MESSAGE &&
					st_reg.outReady) begin
				st_next.outReady = 1'b0;
			end
		end
		st_next.rxValid = 1'b0;
		if (st_reg.inBusy && !inServiceRoutine && rxTake) begin
			st_next.rxByte = st_reg.inMsg;
			st_next.rxValid = 1'b1;
			st_next.inBusy = 1'b0;
		end
		// core refills only after the previous byte has been read
		if (txLoad && !st_reg.outReady && !st_next.outReady &&
				!st_reg.accessOn) begin
			st_next.outMsg = txByte;
			st_next.outReady = 1'b1;
		end
		st_next.irq_n = ~(st_next.outReady & bootDone);
	end
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '0;
			st_reg.irq_n <= 1'b1;
		end else if (clkEn) begin
			st_reg <= st_next;
		end
	end
	assign bus.devData = st_reg.devData;
	assign bus.devDataOe = st_reg.devDataOe;
	assign bus.message_pending_irq_n = st_reg.irq_n;
	assign rxByte = st_reg.rxByte;
	assign rxValid = st_reg.rxValid;
	assign txSpace = ~st_reg.outReady;
	assign extMemEnable = 1'b0;
	assign pcmByte = st_reg.pcmByte;
	assign pcmValid = st_reg.pcmValid;
	assign cmpByte = st_reg.cmpByte;
	assign cmpValid = st_reg.cmpValid;
endmodule // phm_device

/* phm_host.sv */
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
module phm_host (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        clkEn,
	phm_if.host              bus,
	input  wire logic        wbCyc,
	input  wire logic        wbStb,
	input  wire logic        wbWe,
	input  wire logic [3:0]  wbAdr,
	input  wire logic [3:0]  wbSel,
	input  wire logic [31:0] wbDatW,
	output logic      [31:0] wbDatR,
	output logic             wbAck
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		phm_pkg::phm_host_state_t fsm;
		logic [2:0]  irqSync;
		logic        txPend;
		logic [7:0]  txByte;
		logic        rxWant;
		logic [7:0]  rxByte;
		logic        rxValid;
		logic        unsol;
		logic        strobeMode;
		logic        doRead;
		logic [1:0]  addr;
		logic [2:0]  phase;
		logic [13:0] waitCnt;
		logic        armWait;
		logic        csN;
		logic        wrN;
		logic        rdN;
		logic        dsN;
		logic        rnw;
		logic        oe;
		logic [7:0]  dOut;
		logic [31:0] datR;
		logic        ack;
	} phm_host_reg_t;
	phm_host_reg_t st_reg;
	phm_host_reg_t st_next;
	logic wbReq;
	always_comb begin
		st_next = st_reg;
		st_next.ack = 1'b0;
		st_next.irqSync = {st_reg.irqSync[1:0], ~bus.message_pending_irq_n};
		wbReq = wbCyc & wbStb & ~st_reg.ack;
		if (wbReq) begin
			st_next.ack = 1'b1;
			st_next.datR = 32'h0000_0000;
			unique case (wbAdr)
				phm_pkg::WB_TX_DATA: if (wbWe && wbSel[0] && !st_reg.txPend) begin
					st_next.txByte = wbDatW[7:0];
					st_next.txPend = 1'b1;
				end
				phm_pkg::WB_RX_DATA: begin
					st_next.datR[7:0] = st_reg.rxByte;
					if (!wbWe) st_next.rxValid = 1'b0;
				end
				phm_pkg::WB_STATUS: begin
					st_next.datR[phm_pkg::ST_TX_BUSY] = st_reg.txPend;
					st_next.datR[phm_pkg::ST_RX_VALID] = st_reg.rxValid;
					st_next.datR[phm_pkg::ST_UNSOL] = st_reg.unsol;
					st_next.datR[phm_pkg::ST_IRQ] =
						st_reg.irqSync[1] & st_reg.irqSync[2];
					if (wbWe && wbSel[0] && wbDatW[phm_pkg::ST_RX_VALID])
						st_next.rxWant = 1'b1;
					if (wbWe && wbSel[0] && wbDatW[phm_pkg::ST_UNSOL])
						st_next.unsol = 1'b0;
				end
				phm_pkg::WB_CONFIG: begin
					st_next.datR[phm_pkg::CFG_STROBE_MODE] = st_reg.strobeMode;
					if (wbWe && wbSel[0])
						st_next.strobeMode = wbDatW[phm_pkg::CFG_STROBE_MODE];
				end
				default: ;
			endcase
		end
		if (st_reg.waitCnt != 14'h0000)
			st_next.waitCnt = st_reg.waitCnt - 14'h0001;
		unique case (st_reg.fsm)
			phm_pkg::H_IDLE: begin
				if (st_reg.txPend || (st_reg.rxWant && !st_reg.rxValid)) begin
					st_next.doRead = ~st_reg.txPend;
					st_next.addr = phm_pkg::ADDR_CONTROL;
					st_next.fsm = phm_pkg::H_POLL;
				end else if (st_reg.armWait && st_reg.waitCnt == 14'h0000) begin
					st_next.armWait = 1'b0;
					st_next.doRead = 1'b1;
					st_next.addr = phm_pkg::ADDR_CONTROL;
					st_next.fsm = phm_pkg::H_POLL;
				end
			end
			phm_pkg::H_POLL, phm_pkg::H_XFER: begin
				st_next.phase = st_reg.phase + 3'h1;
				st_next.rnw = (st_reg.fsm == phm_pkg::H_POLL) | st_reg.doRead;
				// hold off the data drive one cycle: the device releases
				// its drive from the last poll late, through its synchroniser
				st_next.oe = ~st_next.rnw & (st_reg.phase != 3'h0);
				st_next.dOut = st_reg.txByte;
				st_next.csN = 1'b0;
				st_next.wrN = st_reg.strobeMode | st_next.rnw;
				st_next.rdN = st_reg.strobeMode | ~st_next.rnw;
				st_next.dsN = ~st_reg.strobeMode;
				if (st_reg.phase == 3'(phm_pkg::STROBE_LOW_CYC)) begin
					st_next.phase = 3'h0;
					st_next.csN = 1'b1;
					st_next.wrN = 1'b1;
					st_next.rdN = 1'b1;
					st_next.dsN = 1'b1;
					st_next.fsm = (st_reg.fsm == phm_pkg::H_POLL) ?
						phm_pkg::H_CHECK : phm_pkg::H_GAP;
					if (st_reg.fsm == phm_pkg::H_POLL)
						st_next.datR = {24'h000000, bus.devData};
					else if (st_reg.doRead) begin
						st_next.rxByte = bus.devData;
						st_next.rxValid = 1'b1;
						st_next.rxWant = 1'b0;
						if (!st_reg.rxWant) st_next.unsol = 1'b1;
						st_next.armWait = 1'b1;
						st_next.waitCnt = 14'(phm_pkg::UNSOLICITED_WAIT_CYC);
					end else
						st_next.txPend = 1'b0;
				end
			end
			phm_pkg::H_CHECK: begin
				st_next.oe = 1'b0;
				st_next.addr = phm_pkg::ADDR_MESSAGE;
				// keep polling until the condition holds; an unsolicited ready check instead gives up through H_GAP
				if (st_reg.doRead ? st_reg.datR[phm_pkg::BIT_OUT_READY]
						: !st_reg.datR[phm_pkg::BIT_IN_BUSY])
					st_next.fsm = phm_pkg::H_XFER;
				else begin
					st_next.addr = phm_pkg::ADDR_CONTROL;
					st_next.fsm = st_reg.doRead && !st_reg.rxWant ?
						phm_pkg::H_GAP : phm_pkg::H_POLL;
				end
			end
			phm_pkg::H_GAP: begin
				st_next.oe = 1'b0;
				st_next.fsm = phm_pkg::H_IDLE;
			end
			default: st_next.fsm = phm_pkg::H_IDLE;
		endcase
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '0;
			st_reg.csN <= 1'b1;
			st_reg.wrN <= 1'b1;
			st_reg.rdN <= 1'b1;
			st_reg.dsN <= 1'b1;
			st_reg.rnw <= 1'b1;
		end else if (clkEn) begin
			st_reg <= st_next;
		end
	end
	assign bus.chipSel_n = st_reg.csN;
	assign bus.writeStrobe_n = st_reg.wrN;
	assign bus.readStrobe_n = st_reg.rdN;
	assign bus.data_strobe_n = st_reg.dsN;
	assign bus.readNotWrite = st_reg.rnw;
	assign bus.regAddr = st_reg.addr;
	assign bus.hostData = st_reg.dOut;
	assign bus.hostDataOe = st_reg.oe;
	assign bus.strobeMode = st_reg.strobeMode;
	assign wbDatR = st_reg.datR;
	assign wbAck = st_reg.ack;
endmodule // phm_host

/* phm_properties.sv */
`timescale 1ns/1ps
module phm_properties (
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic       chipSel_n,
	input wire logic       writeStrobe_n,
	input wire logic       readStrobe_n,
	input wire logic       data_strobe_n,
	input wire logic       readNotWrite,
	input wire logic [1:0] regAddr,
	input wire logic       hostDataOe,
	input wire logic [7:0] devData,
	input wire logic       devDataOe,
	input wire logic       message_pending_irq_n,
	input wire logic       strobeMode
);
	// ----
	// helpers
	// ----
	logic       rdReq;
	logic [3:0] sinceRd_reg;
	assign rdReq = !chipSel_n &&
		(strobeMode ? (!data_strobe_n && readNotWrite) : !readStrobe_n);
	// saturates so a stale read never excuses an irq release
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			sinceRd_reg <= 4'hF;
		else if (rdReq && regAddr == phm_pkg::ADDR_MESSAGE)
			sinceRd_reg <= 4'h0;
		else if (sinceRd_reg != 4'hF)
			sinceRd_reg <= sinceRd_reg + 4'h1;
	end
	// ----
	// properties
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence rdStart;
		$rose(rdReq) && regAddr <= phm_pkg::ADDR_CONTROL;
	endsequence
	sequence dataAnswer;
		##[1:6] devDataOe;
	endsequence
	sequence selHeld;
		(!chipSel_n) [*4];
	endsequence
	read_answer_a: assert property (
		rdStart |-> dataAnswer)
		else $error("read data late");
	oe_readable_a: assert property (
		$rose(devDataOe) |->
		!$past(chipSel_n) && regAddr <= phm_pkg::ADDR_CONTROL)
		else $error("drive on unreadable select");
	oe_release_a: assert property (
		$rose(chipSel_n) |-> ##[0:5] !devDataOe)
		else $error("drive held after cycle");
	no_contention_a: assert property (
		!(hostDataOe && devDataOe))
		else $error("both ends drive data");
	strobe_width_a: assert property (
		$fell(chipSel_n) |-> selHeld)
		else $error("select too short");
	cycle_end_a: assert property (
		$rose(chipSel_n) |-> (strobeMode ? data_strobe_n :
		(readStrobe_n && writeStrobe_n)))
		else $error("strobe left low");
	addr_hold_a: assert property (
		!chipSel_n && !$past(chipSel_n) |->
		$stable(regAddr) && $stable(readNotWrite))
		else $error("select lines moved in cycle");
	irq_ready_a: assert property (
		devDataOe && regAddr == phm_pkg::ADDR_CONTROL &&
		!message_pending_irq_n && !$past(message_pending_irq_n, 4) |->
		devData[phm_pkg::BIT_OUT_READY])
		else $error("irq without ready");
	irq_clear_a: assert property (
		$rose(message_pending_irq_n) |-> sinceRd_reg != 4'hF)
		else $error("irq released without read");
endmodule // phm_properties

/* parallel_host_message_port_bench.sv */
`timescale 1ns/1ps
module parallel_host_message_port_bench;
	// ----
	// signals
	// ----
	typedef struct packed {
		logic       rd;
		logic       run;
		logic       mode;
		logic [7:0] val;
	} phm_row_t;
	// boot in separate-strobe mode, run time in data-strobe mode
	localparam phm_row_t ROWS [13] = '{
		'{1'b0, 1'b0, 1'b0, 8'h00}, '{1'b0, 1'b0, 1'b0, 8'h00},
		'{1'b0, 1'b0, 1'b0, 8'h04}, '{1'b1, 1'b0, 1'b0, 8'h01},
		'{1'b0, 1'b1, 1'b1, 8'h80}, '{1'b0, 1'b1, 1'b1, 8'h12},
		'{1'b0, 1'b1, 1'b1, 8'h34}, '{1'b1, 1'b1, 1'b1, 8'h6F},
		'{1'b1, 1'b1, 1'b1, 8'hA1}, '{1'b1, 1'b1, 1'b1, 8'hB2},
		'{1'b1, 1'b1, 1'b1, 8'hC3}, '{1'b1, 1'b1, 1'b1, 8'hD4},
		'{1'b1, 1'b1, 1'b1, 8'hE5}};
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        isr = 1'b0;
	logic        bootDone = 1'b0;
	logic [7:0]  txByte = 8'h00;
	logic        txLoad = 1'b0;
	logic        wbCyc = 1'b0;
	logic        wbStb = 1'b0;
	logic        wbWe = 1'b0;
	logic [3:0]  wbAdr = 4'h0;
	logic [31:0] wbDatW = 32'h0;
	logic [31:0] wbDatR;
	logic        wbAck;
	logic [7:0]  rxByte;
	logic        rxValid;
	logic        txSpace;
	logic        extMem;
	logic [7:0]  rxQ[$];
	int          errCount = 0;
	int          cmpCount = 0;
	always #5 clk = ~clk;
	always @(posedge clk) if (rxValid === 1'b1) rxQ.push_back(rxByte);
	phm_if link ();
	phm_device phm_device_i (.clk(clk), .nrst(nrst), .clkEn(1'b1),
		.bus(link), .inServiceRoutine(isr), .bootDone(bootDone),
		.rxByte(rxByte), .rxValid(rxValid), .rxTake(1'b1),
		.txByte(txByte), .txLoad(txLoad), .txSpace(txSpace),
		.extMemEnable(extMem), .pcmByte(), .pcmValid(), .cmpByte(),
		.cmpValid());
	phm_host phm_host_i (.clk(clk), .nrst(nrst), .clkEn(1'b1),
		.bus(link), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
		.wbAdr(wbAdr), .wbSel(4'hF), .wbDatW(wbDatW), .wbDatR(wbDatR),
		.wbAck(wbAck));
	phm_properties phm_properties_i (.clk(clk), .nrst(nrst),
		.chipSel_n(link.chipSel_n), .writeStrobe_n(link.writeStrobe_n),
		.readStrobe_n(link.readStrobe_n),
		.data_strobe_n(link.data_strobe_n),
		.readNotWrite(link.readNotWrite), .regAddr(link.regAddr),
		.hostDataOe(link.hostDataOe), .devData(link.devData),
		.devDataOe(link.devDataOe), .strobeMode(link.strobeMode),
		.message_pending_irq_n(link.message_pending_irq_n));
	// ----
	// tasks
	// ----
	task automatic chkWord(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmpCount++;
		if (g !== e) begin
			errCount++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chkBit(input string nm, input logic e, input logic g);
		cmpCount++;
		if (g !== e) begin
			errCount++;
			$display("ERROR %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic tallyAndFinish();
		if (errCount == 0 && cmpCount > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic hang(input string nm);
		errCount++;
		$display("ERROR %s expected answer seen timeout", nm);
		tallyAndFinish();
	endtask
	task automatic wbXfer(input logic we, input logic [3:0] adr,
		input logic [31:0] d, output logic [31:0] q);
		int n = 0;
		@(posedge clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= adr;
		wbDatW <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wbAck !== 1'b1 && n < 50);
		if (wbAck !== 1'b1) hang("wbAck");
		q = wbDatR;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask
	task automatic pollStatus(input int bitNo, input logic want);
		logic [31:0] q;
		int          n = 0;
		do begin
			wbXfer(1'b0, phm_pkg::WB_STATUS, 32'h0, q);
			n++;
		end while (q[bitNo] !== want && n < 6000);
		if (q[bitNo] !== want) hang("status");
	endtask
	task automatic hostRecv(output logic [7:0] b);
		logic [31:0] q;
		wbXfer(1'b1, phm_pkg::WB_STATUS, 32'h1 << phm_pkg::ST_RX_VALID, q);
		pollStatus(phm_pkg::ST_RX_VALID, 1'b1);
		wbXfer(1'b0, phm_pkg::WB_RX_DATA, 32'h0, q);
		b = q[7:0];
	endtask
	task automatic coreSend(input logic [7:0] b);
		int n = 0;
		while (txSpace !== 1'b1 && n < 500) begin
			@(posedge clk);
			n++;
		end
		if (txSpace !== 1'b1) hang("txSpace");
		txByte <= b;
		txLoad <= 1'b1;
		@(posedge clk);
		txLoad <= 1'b0;
	endtask
	task automatic waitRx(input logic [7:0] e);
		int n = 0;
		while (rxQ.size() == 0 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		if (rxQ.size() == 0) hang("rxByte");
		chkWord("rxByte", {24'h0, e}, {24'h0, rxQ.pop_front()});
	endtask
	// ----
	// sequence
	// ----
	initial begin
		logic [31:0] q;
		logic [7:0]  b;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		wbXfer(1'b0, phm_pkg::WB_STATUS, 32'h0, q);
		chkWord("status", 32'h0, q);
		wbXfer(1'b0, 4'h2, 32'h0, q);
		chkWord("unmapped", 32'h0, q);
		chkBit("irqIdle", 1'b1, link.message_pending_irq_n);
		chkBit("extMem", 1'b0, extMem);
		for (int i = 0; i < 13; i++) begin
			bootDone <= ROWS[i].run;
			wbXfer(1'b1, phm_pkg::WB_CONFIG, {31'h0, ROWS[i].mode}, q);
			if (ROWS[i].rd) begin
				coreSend(ROWS[i].val);
				repeat (8) @(posedge clk);
				chkBit("irq", !ROWS[i].run, link.message_pending_irq_n);
				wbXfer(1'b0, phm_pkg::WB_STATUS, 32'h0, q);
				chkBit("irqStatus", ROWS[i].run, q[phm_pkg::ST_IRQ]);
				hostRecv(b);
				chkWord("reply", {24'h0, ROWS[i].val}, {24'h0, b});
				chkBit("irqDone", 1'b1, link.message_pending_irq_n);
			end else begin
				pollStatus(phm_pkg::ST_TX_BUSY, 1'b0);
				wbXfer(1'b1, phm_pkg::WB_TX_DATA, {24'h0, ROWS[i].val}, q);
				waitRx(ROWS[i].val);
			end
		end
		// core in its service routine: byte waits, a second byte is held back
		isr <= 1'b1;
		wbXfer(1'b1, phm_pkg::WB_TX_DATA, 32'hA5, q);
		repeat (30) @(posedge clk);
		chkWord("held", 32'h0, 32'(rxQ.size()));
		wbXfer(1'b1, phm_pkg::WB_TX_DATA, 32'h3C, q);
		repeat (30) @(posedge clk);
		wbXfer(1'b0, phm_pkg::WB_STATUS, 32'h0, q);
		chkBit("txBusy", 1'b1, q[phm_pkg::ST_TX_BUSY]);
		isr <= 1'b0;
		waitRx(8'hA5);
		waitRx(8'h3C);
		repeat (60) @(posedge clk);
		chkWord("dropped", 32'h0, 32'(rxQ.size()));
		// unsolicited byte shows only after the recheck delay
		coreSend(8'h5A);
		wbXfer(1'b0, phm_pkg::WB_STATUS, 32'h0, q);
		chkBit("unsolEarly", 1'b0, q[phm_pkg::ST_UNSOL]);
		pollStatus(phm_pkg::ST_UNSOL, 1'b1);
		wbXfer(1'b1, phm_pkg::WB_STATUS, 32'h1 << phm_pkg::ST_UNSOL, q);
		wbXfer(1'b0, phm_pkg::WB_STATUS, 32'h0, q);
		chkBit("unsolClr", 1'b0, q[phm_pkg::ST_UNSOL]);
		hostRecv(b);
		chkWord("unsolByte", 32'h5A, {24'h0, b});
		// reset in mid-run with a byte pending
		coreSend(8'h77);
		repeat (8) @(posedge clk);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		chkBit("irqReset", 1'b1, link.message_pending_irq_n);
		wbXfer(1'b0, phm_pkg::WB_STATUS, 32'h0, q);
		chkWord("statusReset", 32'h0, q);
		tallyAndFinish();
	end
endmodule // parallel_host_message_port_bench
